/* rtl/wkt_pkg.sv */
package wkt_pkg;
  localparam logic [7:0] ADDR_CONTROL     = 8'h23;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h24;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h25;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h26;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'h27;
  localparam logic [7:0] ADDR_STATUS      = 8'h2F;
  localparam int BIT_RUNNING   = 7;
  localparam int BIT_RUN_WE    = 6;
  localparam int BIT_AUTO_TRIM = 5;
  localparam int BIT_AUTO_CD   = 4;
  localparam int BIT_RELOAD    = 3;
  localparam int BIT_AUTO_WAKE = 2;
  localparam int BIT_IRQ_FLAG  = 0;
  localparam int BIT_CARD_IRQ  = 1;
  localparam logic [1:0] CLK_DIV1  = 2'h0;
  localparam logic [1:0] CLK_DIV8  = 2'h1;
  localparam logic [1:0] CLK_DIV16 = 2'h2;
  localparam logic [4:0] PRE_DIV8  = 5'h07;
  localparam logic [4:0] PRE_DIV16 = 5'h0F;
  localparam logic [4:0] PRE_DIV32 = 5'h1F;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  typedef enum logic [1:0]
  {
    WKT_IDLE = 2'b00,
    WKT_WAIT = 2'b01
  } wkt_cd_t;
endpackage : wkt_pkg

/* rtl/wkt_timer.sv */
`timescale 1ns/10ps
module wkt_timer
  import wkt_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port.
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Low-frequency oscillator tick, asynchronous level.
  input  wire logic       low_freq_oscillator,
  // Card detection handshake.
  output logic            trim_start,
  output logic            card_detect_start,
  input  wire logic       card_detect_done,
  input  wire logic       card_found,
  input  wire logic       card_irq_enable,
  input  wire logic       power_down_enable,
  // System effects.
  output logic            wake_request,
  output logic            power_down_request,
  output logic            card_irq,
  output logic            wake_timer_irq_flag
);
  logic [2:0]  osc_sync;
  logic [4:0]  prescale;
  logic        tick;
  logic        wake_timer_running;
  logic        auto_osc_trim_on_underflow;
  logic        auto_card_detect_on_underflow;
  logic        wake_timer_auto_reload;
  logic        auto_wake_on_underflow;
  logic [1:0]  wake_timer_clock_select;
  logic [7:0]  wakeup_reload_high;
  logic [7:0]  wakeup_reload_low;
  logic [15:0] count;
  logic [15:0] wake_timer_reload_value;
  logic        underflow;
  logic        ctrl_wr;
  logic        sw_start;
  logic        sw_stop;
  logic [4:0]  pre_limit;
  wkt_cd_t     cd_state;
  logic        osc_rise;
  logic        status_wr;
  logic        clear_wake_irq;
  logic        clear_card_irq;
  logic        card_hit;
  logic        card_miss;
  logic        count_step;
  logic        reload_at_zero;
  logic [7:0]  control_view;
  logic [7:0]  status_view;
  logic [7:0]  next_rdata;

  // How the block hangs together: the slow oscillator is brought into
  // the system clock domain, each of its rising edges is counted by a
  // prescaler, and the prescaler hands the down-counter a one-cycle
  // enable. Everything else runs off the system clock, so the register
  // port never has to cross a domain. The price is that the oscillator
  // must stay well below half the system clock for every edge to be seen.
  // The card detection run and the oscillator trim run are only started
  // from here; their own sequencing belongs to the blocks that receive
  // the start pulses. This block only tracks the outcome of a detection
  // run, so that it can raise the card flag or ask for power-down.
  // Two flags are kept: the wake flag, set at every underflow, and the
  // card flag, set when a detection run finds a card and the host allows
  // it. Both are sticky and drop only when software writes a one.

  // Oscillator passes two flops; the third flop only feeds edge detection.
  // The first flop may go metastable, so nothing but the second reads it.
  // An edge is seen two to three system cycles after it happens on the
  // pin; that delay is far below one oscillator period and is harmless.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      osc_sync <= 3'h0;
    else
      osc_sync <= {osc_sync[1:0], low_freq_oscillator};
  end

  // Prescaler limit from the clock select field.
  // Each limit is the number of oscillator edges per tick less one:
  //   select 0: every oscillator edge
  //   select 1: every 8th edge, 2: every 16th edge, 3: every 32nd edge
  always_comb
  begin
    case (wake_timer_clock_select)
      CLK_DIV1:  pre_limit = 5'h00;
      CLK_DIV8:  pre_limit = PRE_DIV8;
      CLK_DIV16: pre_limit = PRE_DIV16;
      default:   pre_limit = PRE_DIV32;
    endcase
  end

  // Divider turns oscillator rising edges into one-cycle count enables.
  // It is cleared while the timer stands, so every start from standstill begins a full
  // edge count; the first tick can still come up to one input period short.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prescale <= 5'h00;
      tick     <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (!wake_timer_running)
        prescale <= 5'h00;
      else if (osc_rise)
      begin
        if (prescale >= pre_limit)
        begin
          prescale <= 5'h00;
          tick     <= 1'b1;
        end
        else
          prescale <= prescale + 5'h01;
      end
    end
  end

  // Register map, one byte each:
  //   control      - running (read), start/stop-now (write), trim, card
  //                  detect, auto reload, auto wake, clock select
  //   reload high  - upper reload byte, read and write
  //   reload low   - lower reload byte, read and write
  //   count high   - upper byte of the live count, read only
  //   count low    - lower byte of the live count, read only
  //   status       - wake flag in bit 0, card flag in bit 1; writing a one
  //                  clears the flag, writing a zero leaves it alone
  // Writes to the count bytes and to unmapped addresses have no effect,
  // and unmapped reads return zero.

  // Register decodes and the underflow event.
  assign wake_timer_reload_value = {wakeup_reload_high, wakeup_reload_low};
  assign ctrl_wr   = wr && (addr == ADDR_CONTROL);
  assign sw_start  = ctrl_wr && wdata[BIT_RUN_WE] && wdata[BIT_RUNNING];
  assign sw_stop   = ctrl_wr && wdata[BIT_RUN_WE] && !wdata[BIT_RUNNING];
  assign underflow = tick && wake_timer_running && (count == COUNT_ZERO);

  // The oscillator edge as seen after the second synchroniser flop.
  assign osc_rise = osc_sync[1] && !osc_sync[2];

  // Status clears: software writes one to a flag bit to drop it.
  assign status_wr      = wr && (addr == ADDR_STATUS);
  assign clear_wake_irq = status_wr && wdata[BIT_IRQ_FLAG];
  assign clear_card_irq = status_wr && wdata[BIT_CARD_IRQ];

  // Outcome of a card detection run, only trusted while one is pending.
  assign card_hit  = (cd_state == WKT_WAIT) && card_detect_done
                     && card_found;
  assign card_miss = (cd_state == WKT_WAIT) && card_detect_done
                     && !card_found;

  // Plain decrement, and whether an underflow goes round again.
  assign count_step     = tick && wake_timer_running
                          && (count != COUNT_ZERO);
  assign reload_at_zero = wake_timer_auto_reload
                          || auto_card_detect_on_underflow;

  // Read views; the start/stop-now bit is write-only and reads as zero.
  assign control_view = {wake_timer_running, 1'b0,
                         auto_osc_trim_on_underflow,
                         auto_card_detect_on_underflow,
                         wake_timer_auto_reload,
                         auto_wake_on_underflow,
                         wake_timer_clock_select};
  assign status_view  = {6'h00, card_irq, wake_timer_irq_flag};

  // Configuration bits; the start/stop-now bit is never stored.
  // Every control write rewrites all of them, so software must carry the
  // enables along when it only means to start or stop the timer.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      auto_osc_trim_on_underflow    <= 1'b0;
      auto_card_detect_on_underflow <= 1'b0;
      wake_timer_auto_reload        <= 1'b0;
      auto_wake_on_underflow        <= 1'b0;
      wake_timer_clock_select       <= 2'h0;
    end
    else if (ctrl_wr)
    begin
      auto_osc_trim_on_underflow    <= wdata[BIT_AUTO_TRIM];
      auto_card_detect_on_underflow <= wdata[BIT_AUTO_CD];
      wake_timer_auto_reload        <= wdata[BIT_RELOAD];
      auto_wake_on_underflow        <= wdata[BIT_AUTO_WAKE];
      wake_timer_clock_select       <= wdata[1:0];
    end
  end

  // Reload bytes only feed the counter at a software start or an auto restart.
  // The bytes may be written in any order; a start between the two writes
  // would load a half-updated value, so set both before starting.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wakeup_reload_high <= BYTE_ZERO;
      wakeup_reload_low  <= BYTE_ZERO;
    end
    else if (wr)
    begin
      if (addr == ADDR_RELOAD_HIGH)
        wakeup_reload_high <= wdata;
      if (addr == ADDR_RELOAD_LOW)
        wakeup_reload_low <= wdata;
    end
  end

  // Timing of one period: the counter is loaded with the reload value,
  // steps down once per tick and underflows on the tick after it reaches
  // zero, so a period lasts the reload value plus one ticks. At that tick
  // the flag, the pulses and the reload all take effect together; a stop
  // without auto reload leaves the count at zero.
  // A software start and an underflow in the same cycle: the start wins
  // and reloads, and the underflow's flag and pulses still go out.

  // Running flag and counter; software start or auto restart loads reload.
  // A software stop leaves the count where it was, so it can still be read
  // back after the fact; only the next start reloads it.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wake_timer_running <= 1'b0;
      count              <= COUNT_ZERO;
    end
    else if (sw_start)
    begin
      wake_timer_running <= 1'b1;
      count              <= wake_timer_reload_value;
    end
    else if (sw_stop)
      wake_timer_running <= 1'b0;
    else if (underflow)
    begin
      // Card detection forces a gapless restart, else auto-reload decides.
      if (reload_at_zero)
        count <= wake_timer_reload_value;
      else
        wake_timer_running <= 1'b0;
    end
    else if (count_step)
      count <= count - 16'h0001;
  end

  // Wake interrupt flag. A hardware set wins over a software clear in the
  // same cycle, so an underflow that lands on the clear is never lost.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wake_timer_irq_flag <= 1'b0;
    else if (underflow)
      wake_timer_irq_flag <= 1'b1;
    else if (clear_wake_irq)
      wake_timer_irq_flag <= 1'b0;
  end

  // Card interrupt flag, raised only when the host has enabled it; the
  // same set-wins order applies as for the wake flag.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      card_irq <= 1'b0;
    else if (card_hit && card_irq_enable)
      card_irq <= 1'b1;
    else if (clear_card_irq)
      card_irq <= 1'b0;
  end

  // Trim pulse: one cycle, a cycle after the underflow. The trim run and
  // the timer it borrows live outside this block.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      trim_start <= 1'b0;
    else
      trim_start <= underflow && auto_osc_trim_on_underflow;
  end

  // Card detection pulse. The field-on window is timed by timer three
  // outside this block, which is why the run ends with a done pulse.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      card_detect_start <= 1'b0;
    else
      card_detect_start <= underflow
                           && auto_card_detect_on_underflow;
  end

  // Wake pulse; whether the chip then sleeps again is the host's choice.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wake_request <= 1'b0;
    else
      wake_request <= underflow && auto_wake_on_underflow;
  end

  // Card detection tracker: waits from the start pulse to the done pulse.
  // A done pulse outside a pending run is ignored, so a stray pulse from
  // the detector cannot raise an interrupt or put the chip to sleep.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cd_state <= WKT_IDLE;
    else
    begin
      case (cd_state)
        WKT_IDLE:
          if (card_detect_start)
            cd_state <= WKT_WAIT;
        WKT_WAIT:
          if (card_detect_done)
            cd_state <= WKT_IDLE;
        default:
          cd_state <= WKT_IDLE;
      endcase
    end
  end

  // Power-down pulse when a run ends with no card and sleep is allowed.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      power_down_request <= 1'b0;
    else
      power_down_request <= card_miss && power_down_enable;
  end

  // Read multiplexer. The count bytes come straight from the live
  // counter; a two-byte read can straddle a decrement, which software
  // avoids by reading twice or by stopping the timer first.
  always_comb
  begin
    next_rdata = BYTE_ZERO;
    if (rd)
    begin
      case (addr)
        ADDR_CONTROL:     next_rdata = control_view;
        ADDR_RELOAD_HIGH: next_rdata = wakeup_reload_high;
        ADDR_RELOAD_LOW:  next_rdata = wakeup_reload_low;
        ADDR_COUNT_HIGH:  next_rdata = count[15:8];
        ADDR_COUNT_LOW:   next_rdata = count[7:0];
        ADDR_STATUS:      next_rdata = status_view;
        default:          next_rdata = BYTE_ZERO;
      endcase
    end
  end

  // Read data stand for the one cycle after the strobe and are zero
  // otherwise, so a bus that ORs several slaves together stays clean.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= BYTE_ZERO;
    else
      rdata <= next_rdata;
  end
endmodule : wkt_timer

/* verification/wkt_timer_props.sv */
`timescale 1ns/10ps
module wkt_timer_props
  import wkt_pkg::*;
(
  // Clock, reset and register port.
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Card detection handshake and effects.
  input wire logic       card_detect_done,
  input wire logic       card_found,
  input wire logic       card_irq_enable,
  input wire logic       power_down_enable,
  input wire logic       trim_start,
  input wire logic       card_detect_start,
  input wire logic       wake_request,
  input wire logic       power_down_request,
  input wire logic       card_irq,
  input wire logic       wake_timer_irq_flag
);
  logic [7:0] ctrl;
  // Shadow of the control byte, so each pulse can be tied to its enable.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl <= BYTE_ZERO;
    else if (wr && addr == ADDR_CONTROL)
      ctrl <= wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hit;
    card_detect_done && card_found && card_irq_enable;
  endsequence
  sequence s_miss;
    card_detect_done && !card_found && power_down_enable;
  endsequence
  rd_idle_a: assert property (!$past(rd) |-> rdata == BYTE_ZERO)
    else $error("Read data not zero outside a read.");
  unmapped_zero_a: assert property
    (rd && addr == 8'h30 |=> rdata == BYTE_ZERO)
    else $error("Unmapped read not zero.");
  run_we_read_a: assert property
    (rd && addr == ADDR_CONTROL |=> !rdata[BIT_RUN_WE])
    else $error("Start-stop bit reads back as one.");
  // Pulses come a cycle after the underflow, so the enable that launched
  // them is the one held a cycle earlier.
  trim_gate_a: assert property
    (trim_start |-> $past(ctrl[BIT_AUTO_TRIM]))
    else $error("Trim start without its enable.");
  cd_gate_a: assert property
    (card_detect_start |-> $past(ctrl[BIT_AUTO_CD]))
    else $error("Card detect start without its enable.");
  cd_once_a: assert property
    (card_detect_start |=> !card_detect_start)
    else $error("Card detect start longer than one cycle.");
  wake_gate_a: assert property
    (wake_request |-> $past(ctrl[BIT_AUTO_WAKE]))
    else $error("Wake request without its enable.");
  wake_follow_a: assert property
    ($rose(wake_timer_irq_flag) && $past(ctrl[BIT_AUTO_WAKE])
     |-> wake_request)
    else $error("No wake request at underflow.");
  card_irq_a: assert property (s_hit |=> card_irq)
    else $error("Card found but no card interrupt.");
  pd_req_a: assert property (s_miss |=> power_down_request)
    else $error("No card but no power-down request.");
  flag_hold_a: assert property
    (wake_timer_irq_flag && !(wr && addr == ADDR_STATUS && wdata[BIT_IRQ_FLAG])
     |=> wake_timer_irq_flag)
    else $error("Interrupt flag dropped without a clear.");
endmodule : wkt_timer_props

/* verification/test_wakeup_timer_lpcd.sv */
`timescale 1ns/10ps
module test_wakeup_timer_lpcd import wkt_pkg::*;;
  logic clk, rst_n, wr, rd, low_freq_oscillator, card_detect_done;
  logic card_found, card_irq_enable, power_down_enable;
  logic rd_seen = 1'b0;
  logic trim_start, card_detect_start, wake_request, power_down_request;
  logic card_irq, wake_timer_irq_flag;
  logic [7:0]  addr, wdata, rdata;
  logic [7:0]  exp_q[$];
  logic [15:0] rv;
  int          fail_count, checks, cycles;
  int          n_trim, n_cd, n_wake, n_pd;
  wkt_timer uut(.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .low_freq_oscillator, .trim_start, .card_detect_start, .card_detect_done,
    .card_found, .card_irq_enable, .power_down_enable, .wake_request,
    .power_down_request, .card_irq, .wake_timer_irq_flag);
  // Free-running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  // A gap cycle after each strobe keeps a driver from assigning twice.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd_reg
  // Tally every one-cycle pulse the block sends out.
  always @(posedge clk)
  begin
    n_trim <= n_trim + int'(trim_start);
    n_cd   <= n_cd + int'(card_detect_start);
    n_wake <= n_wake + int'(wake_request);
    n_pd   <= n_pd + int'(power_down_request);
  end
  // Pulse tallies and the two flag pins against what the test expects.
  task automatic check_outs(input int t, input int c, input int w,
                            input int p, input logic [1:0] f);
    checks++;
    if (n_trim != t || n_cd != c || n_wake != w || n_pd != p
        || {card_irq, wake_timer_irq_flag} !== f)
    begin
      fail_count++;
      $display("wrong value %0t: pulse tally or flag pins off", $time);
    end
  endtask : check_outs
  // Slow oscillator edges, well apart so the synchroniser settles.
  task automatic tick(input int n);
    repeat (n)
    begin
      low_freq_oscillator <= 1'b1;
      repeat (6) @(posedge clk);
      low_freq_oscillator <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask : tick
  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge clk)
  begin
    if (rd_seen)
    begin
      checks++;
      if (rdata !== exp_q[0])
      begin
        fail_count++;
        $display("wrong value %0t: read %h want %h", $time, rdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
    rd_seen <= rd;
  end
  // Hang guard, far above the roughly nine hundred cycles the run needs.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end
  // Main sequence.
  initial
  begin
    {rst_n, wr, rd, low_freq_oscillator, card_detect_done} = 5'h00;
    {card_found, card_irq_enable, power_down_enable} = 3'h0;
    {addr, wdata} = 16'h0000;
    void'($urandom(31));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(8'h30, 8'h00);
    rv = 16'($urandom());
    wr_reg(ADDR_RELOAD_HIGH, rv[15:8]);
    wr_reg(ADDR_RELOAD_LOW, rv[7:0]);
    rd_reg(ADDR_RELOAD_HIGH, rv[15:8]);
    rd_reg(ADDR_RELOAD_LOW, rv[7:0]);
    wr_reg(ADDR_CONTROL, 8'hC8);
    rd_reg(ADDR_CONTROL, 8'h88);
    rd_reg(ADDR_COUNT_HIGH, rv[15:8]);
    wr_reg(ADDR_RELOAD_HIGH, ~rv[15:8]);
    rd_reg(ADDR_COUNT_HIGH, rv[15:8]);
    rd_reg(ADDR_COUNT_LOW, rv[7:0]);
    wr_reg(ADDR_CONTROL, 8'h40);
    wr_reg(ADDR_CONTROL, 8'h88);
    rd_reg(ADDR_CONTROL, 8'h08);
    $display("test registers done");
    wr_reg(ADDR_RELOAD_HIGH, 8'h00);
    wr_reg(ADDR_RELOAD_LOW, 8'h02);
    wr_reg(ADDR_CONTROL, 8'hEC);
    tick(2);
    rd_reg(ADDR_STATUS, 8'h00);
    tick(1);
    rd_reg(ADDR_STATUS, 8'h01);
    rd_reg(ADDR_COUNT_LOW, 8'h02);
    rd_reg(ADDR_CONTROL, 8'hAC);
    wr_reg(ADDR_STATUS, 8'h01);
    wr_reg(ADDR_CONTROL, 8'hC0);
    tick(3);
    rd_reg(ADDR_CONTROL, 8'h00);
    rd_reg(ADDR_COUNT_LOW, 8'h00);
    check_outs(1, 0, 1, 0, 2'b01);
    $display("test underflow done");
    wr_reg(ADDR_RELOAD_LOW, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(ADDR_STATUS, 8'h01);
      wr_reg(ADDR_CONTROL, 8'hC0 | 8'(s));
      tick(s == 0 ? 0 : (4 << s) - 1);
      rd_reg(ADDR_STATUS, 8'h00);
      tick(1);
      rd_reg(ADDR_STATUS, 8'h01);
    end
    check_outs(1, 0, 1, 0, 2'b01);
    $display("test clock select done");
    card_irq_enable <= 1'b1;
    power_down_enable <= 1'b1;
    wr_reg(ADDR_STATUS, 8'h03);
    wr_reg(ADDR_CONTROL, 8'hD0);
    for (int f = 1; f >= 0; f--)
    begin
      tick(1);
      card_found <= f[0];
      card_detect_done <= 1'b1;
      @(posedge clk);
      card_detect_done <= 1'b0;
      repeat (2) @(posedge clk);
    end
    rd_reg(ADDR_CONTROL, 8'h90);
    rd_reg(ADDR_STATUS, 8'h03);
    check_outs(1, 2, 1, 1, 2'b11);
    $display("test card detect done");
    final_report();
  end
endmodule : test_wakeup_timer_lpcd
bind wkt_timer wkt_timer_props u_props(.clk, .rst_n, .addr, .wdata, .wr,
  .rd, .rdata, .card_detect_done, .card_found, .card_irq_enable,
  .power_down_enable, .trim_start, .card_detect_start, .wake_request,
  .power_down_request, .card_irq, .wake_timer_irq_flag);
